// file: rtl/scs_defs.vh
// constants for the startup configuration status register bank
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
`define SCS_ADDR_W 8
`define SCS_DATA_W 8
`define SCS_OFF_HARD_PIN 8'h09
`define SCS_OFF_TARGET_ADDR 8'h0A
`define SCS_OFF_IMAGE_REV 8'h0B
`define SCS_HARD_PIN_RST 8'h00
`define SCS_TARGET_ADDR_RST 7'h50
`define SCS_IMAGE_REV_RST 8'h00
`define SCS_CODE_W 6
`define SCS_CODE_LSB 2
`define SCS_ADDR_FIELD_LSB 1
`define SCS_LVL_LOW 2'h0
`define SCS_LVL_MID 2'h1
`define SCS_LVL_HIGH 2'h2
`define SCS_LSB_LOW 2'h0
`define SCS_LSB_MID 2'h1
`define SCS_LSB_HIGH 2'h3
`define SCS_LSB_HARD 2'h0
`define SCS_MODE_SOFT 1'b0
`define SCS_MODE_HARD 1'b1
`define SCS_SETTLE_RST 2'h0
`define SCS_SETTLE_CNT 2'h2
`define SCS_CODE_ZERO 6'h00
`define SCS_RSV_ZERO 2'h0
`define SCS_RSV_BIT 1'b0
`define SCS_UNMAPPED_DATA 8'h00
`define SCS_RDATA_RST 8'h00
`endif

// file: rtl/scs_sync.v
// two-flop synchroniser, one per bit, for pins entering the clock domain
`timescale 1ns/1ps
module scs_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_reg;
            reg stable_reg;
            always @(posedge sys_clk_in) begin
                if (sys_rst_in) begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end else if (clk_en_in) begin
                    meta_reg <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate
endmodule // scs_sync

// file: rtl/scs_startup_config_status_regs.v
// read-only startup configuration status registers
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_startup_config_status_regs (
    input wire sys_clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire hard_soft_select_pin_in,
    input wire [5:0] hard_pin_config_code_in,
    input wire [1:0] addr_select_level_in,
    input wire [6:0] nvm_target_address_in,
    input wire [7:0] nvm_image_revision_in,
    input wire nvm_commit_done_in,
    input wire [7:0] reg_addr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    output wire hard_mode_out,
    output wire [6:0] bus_target_address_out
);
    // addr_select_level_in: decoded three-level pin (low/mid/high), from the pad comparators
    // the synchroniser carries {select, code[5:0], level[1:0]}, nine bits in all

    // synchronised pins
    wire [8:0] pins_sync;
    wire sel_sync;
    wire sel_is_hard;
    wire [5:0] code_sync;
    wire [1:0] lvl_sync;
    wire capture_now;

    // read path
    wire hit_hard_pin;
    wire hit_target_addr;
    wire hit_image_rev;
    wire [7:0] hard_pin_image;
    wire [7:0] target_addr_image;
    reg [7:0] rdata_next;
    reg [7:0] rdata_hold_next;
    reg rvalid_next;

    // captured pin status
    reg in_reset_reg;
    reg in_reset_next;
    reg [1:0] settle_reg;
    reg [1:0] settle_next;
    reg hard_mode_reg;
    reg hard_mode_next;
    reg [5:0] code_reg;
    reg [5:0] code_next;
    reg [1:0] addr_lsb_reg;
    reg [1:0] addr_lsb_next;
    reg [1:0] lsb_next;

    // non-volatile copies
    reg [6:0] target_addr_reg;
    reg [6:0] target_addr_next;
    reg [7:0] image_rev_reg;
    reg [7:0] image_rev_next;
    reg reload_pending_reg;
    reg reload_pending_next;

    // pins are asynchronous to the clock, so they are synchronised before capture
    scs_sync #(
        .WIDTH(9)
    ) u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .async_in({hard_soft_select_pin_in, hard_pin_config_code_in, addr_select_level_in}),
        .sync_out(pins_sync)
    );
    assign sel_sync = pins_sync[8];
    assign code_sync = pins_sync[7:2];
    assign lvl_sync = pins_sync[1:0];
    assign sel_is_hard = (sel_sync == `SCS_MODE_HARD);

    // three-level decode; the spare code 3 is taken as high so that no pad
    // reading can ever produce the missing address value 2
    always @* begin
        case (lvl_sync)
            `SCS_LVL_LOW: lsb_next = `SCS_LSB_LOW;
            `SCS_LVL_MID: lsb_next = `SCS_LSB_MID;
            `SCS_LVL_HIGH: lsb_next = `SCS_LSB_HIGH;
            default: lsb_next = `SCS_LSB_HIGH;
        endcase
    end

    // capture waits for the synchroniser to flush the zeros it held in reset,
    // so pins must stay put for three enabled clocks after release
    assign capture_now = in_reset_reg && (settle_reg == `SCS_SETTLE_CNT);

    always @* begin
        in_reset_next = in_reset_reg;
        settle_next = settle_reg;
        hard_mode_next = hard_mode_reg;
        code_next = code_reg;
        addr_lsb_next = addr_lsb_reg;
        if (capture_now) begin
            in_reset_next = 1'b0;
            hard_mode_next = sel_sync;
            if (sel_is_hard) begin
                code_next = code_sync;
                addr_lsb_next = `SCS_LSB_HARD;
            end else begin
                code_next = `SCS_CODE_ZERO;
                addr_lsb_next = lsb_next;
            end
        end else if (in_reset_reg) begin
            settle_next = settle_reg + 2'h1;
        end
    end

    // once captured only the next reset touches these, which holds them
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            in_reset_reg <= 1'b1;
            settle_reg <= `SCS_SETTLE_RST;
            hard_mode_reg <= `SCS_MODE_SOFT;
            code_reg <= `SCS_CODE_ZERO;
            addr_lsb_reg <= `SCS_LSB_LOW;
        end else if (clk_en_in) begin
            in_reset_reg <= in_reset_next;
            settle_reg <= settle_next;
            hard_mode_reg <= hard_mode_next;
            code_reg <= code_next;
            addr_lsb_reg <= addr_lsb_next;
        end
    end

    // non-volatile contents arrive from on-chip logic in this clock domain;
    // the first enabled clock after reset reloads both, a commit only the revision
    always @* begin
        reload_pending_next = 1'b0;
        target_addr_next = target_addr_reg;
        image_rev_next = image_rev_reg;
        if (reload_pending_reg) begin
            target_addr_next = nvm_target_address_in;
            image_rev_next = nvm_image_revision_in;
        end else if (nvm_commit_done_in) begin
            image_rev_next = nvm_image_revision_in;
        end
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            target_addr_reg <= `SCS_TARGET_ADDR_RST;
            image_rev_reg <= `SCS_IMAGE_REV_RST;
            reload_pending_reg <= 1'b1;
        end else if (clk_en_in) begin
            target_addr_reg <= target_addr_next;
            image_rev_reg <= image_rev_next;
            reload_pending_reg <= reload_pending_next;
        end
    end

    assign hard_mode_out = hard_mode_reg;
    // address used by the serial-bus front end to match its own transactions;
    // the stored low two bits are replaced by the pin or forced value
    assign bus_target_address_out = {target_addr_reg[6:2], addr_lsb_reg};

    // register images; reserved bits read zero so a careless host sees no noise
    assign hard_pin_image = {code_reg, `SCS_RSV_ZERO};
    assign target_addr_image = {bus_target_address_out, `SCS_RSV_BIT};

    // offset decode
    assign hit_hard_pin = (reg_addr_in == `SCS_OFF_HARD_PIN);
    assign hit_target_addr = (reg_addr_in == `SCS_OFF_TARGET_ADDR);
    assign hit_image_rev = (reg_addr_in == `SCS_OFF_IMAGE_REV);

    always @* begin
        rdata_next = `SCS_UNMAPPED_DATA;
        if (hit_hard_pin) begin
            rdata_next = hard_pin_image;
        end else if (hit_target_addr) begin
            rdata_next = target_addr_image;
        end else if (hit_image_rev) begin
            rdata_next = image_rev_reg;
        end
    end

    // rvalid repeats reg_rd_in one enabled clock later; rdata holds until the next read so a slow
    // host can still pick it up later
    always @* begin
        rvalid_next = reg_rd_in;
        rdata_hold_next = reg_rdata_out;
        if (reg_rd_in) begin
            rdata_hold_next = rdata_next;
        end
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= `SCS_RDATA_RST;
            reg_rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            reg_rdata_out <= rdata_hold_next;
            reg_rvalid_out <= rvalid_next;
        end
    end
endmodule // scs_startup_config_status_regs

// file: tb/scs_regs_checker.sv
// assertions on the status register bank ports
`timescale 1ns/1ps
module scs_regs_checker (
    input wire sys_clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire [7:0] reg_addr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire reg_rvalid_out,
    input wire hard_mode_out,
    input wire [6:0] bus_target_address_out
);
    reg [2:0] cnt_reg;
    wire rd = reg_rd_in && clk_en_in;
    // pins settle through the synchroniser before the hold check starts
    always @(posedge sys_clk_in) begin
        if (sys_rst_in)
            cnt_reg <= 3'h0;
        else if (clk_en_in && cnt_reg != 3'h7)
            cnt_reg <= cnt_reg + 3'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_RD_ACK: assert property (rd ##1 clk_en_in |-> reg_rvalid_out)
        else $error("read not answered");
    AST_RD_IDLE: assert property (clk_en_in && !reg_rd_in |=> !reg_rvalid_out)
        else $error("answer without read");
    AST_HARD_RSV: assert property (rd && reg_addr_in == 8'h09 |=> reg_rdata_out[1:0] == 2'h0)
        else $error("reserved config bits set");
    AST_SOFT_CODE: assert property (rd && reg_addr_in == 8'h09 && !hard_mode_out
        |=> reg_rdata_out == 8'h00)
        else $error("soft mode code not zero");
    AST_ADDR_RD: assert property (rd && reg_addr_in == 8'h0A
        |=> reg_rdata_out == {$past(bus_target_address_out), 1'b0})
        else $error("address read mismatch");
    AST_HARD_LSB: assert property (hard_mode_out |-> bus_target_address_out[1:0] == 2'h0)
        else $error("hard mode address lsbs");
    AST_LSB_LEGAL: assert property (bus_target_address_out[1:0] != 2'h2)
        else $error("illegal address lsbs");
    AST_HOLD: assert property (cnt_reg >= 3'h5
        |-> $stable(hard_mode_out) && $stable(bus_target_address_out))
        else $error("captured status changed");
    AST_RELEASE: assert property ($fell(sys_rst_in)
        |-> !hard_mode_out && !reg_rvalid_out && bus_target_address_out == 7'h50)
        else $error("reset values wrong");
    AST_UNMAPPED: assert property (rd && (reg_addr_in < 8'h09 || reg_addr_in > 8'h0B)
        |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    cover property (rd && reg_addr_in == 8'h09 && hard_mode_out);
    cover property (rd && reg_addr_in == 8'h0A && !hard_mode_out);
    cover property (rd && reg_addr_in == 8'h0B);
endmodule // scs_regs_checker
bind scs_startup_config_status_regs scs_regs_checker u_chk (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .hard_mode_out(hard_mode_out), .bus_target_address_out(bus_target_address_out));

// file: tb/scs_host_model.sv
// host side model issuing register reads
`timescale 1ns/1ps
module scs_host_model (
    input wire sys_clk_in,
    input wire [7:0] rdata_in,
    input wire rvalid_in,
    output reg [7:0] addr_out,
    output reg rd_out
);
    initial begin
        addr_out = 8'h00;
        rd_out = 1'b0;
    end
    // answer is fixed one cycle after the strobe, so no open-ended wait
    task read(input [7:0] a, output [7:0] d);
        begin
            @(posedge sys_clk_in);
            addr_out <= a;
            rd_out <= 1'b1;
            @(posedge sys_clk_in);
            rd_out <= 1'b0;
            @(posedge sys_clk_in);
            d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
            addr_out <= ~a;
        end
    endtask
endmodule // scs_host_model

// file: tb/tb_top.sv
// bench for the startup configuration status registers
`timescale 1ns/1ps
module tb_top;
    reg sys_clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg mode = 1'b0;
    reg [5:0] code = 6'h00;
    reg [1:0] lvl = 2'h0;
    reg [6:0] nvm_addr = 7'h55;
    reg [7:0] nvm_rev = 8'h5A;
    reg commit = 1'b0;
    reg en = 1'b1;
    reg [7:0] d;
    wire [7:0] addr, rdata;
    wire rd, rvalid, hmode;
    wire [6:0] taddr;
    integer failures = 0, samples_checked = 0, cycles = 0, i;
    initial forever #50 sys_clk_in = ~sys_clk_in;
    scs_startup_config_status_regs u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(en), .hard_soft_select_pin_in(mode), .hard_pin_config_code_in(code),
        .addr_select_level_in(lvl), .nvm_target_address_in(nvm_addr),
        .nvm_image_revision_in(nvm_rev), .nvm_commit_done_in(commit), .reg_addr_in(addr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .hard_mode_out(hmode), .bus_target_address_out(taddr));
    scs_host_model u_host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .addr_out(addr), .rd_out(rd));
    task chk(input [7:0] g, input [7:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[ERR] t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task boot(input m, input [5:0] c, input [1:0] l);
        begin
            @(posedge sys_clk_in);
            sys_rst_in <= 1'b1;
            mode <= m;
            code <= c;
            lvl <= l;
            repeat (2) @(posedge sys_clk_in);
            sys_rst_in <= 1'b0;
            repeat (5) @(posedge sys_clk_in);
        end
    endtask
    task t_hard;
        begin
            boot(1'b1, 6'h3F, 2'h1);
            u_host.read(8'h09, d);
            chk(d, 8'hFC);
            u_host.read(8'h0A, d);
            chk(d, {nvm_addr[6:2], 3'h0});
            chk({7'h00, hmode}, 8'h01);
            mode <= 1'b0;
            code <= 6'h00;
            repeat (5) @(posedge sys_clk_in);
            u_host.read(8'h09, d);
            chk(d, 8'hFC);
            $display("hard mode test done");
        end
    endtask
    // high level and the spare level code both map to 3, never 2
    task t_soft;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                boot(1'b0, 6'h2A, i[1:0]);
                u_host.read(8'h09, d);
                chk(d, 8'h00);
                u_host.read(8'h0A, d);
                chk(d, {nvm_addr[6:2], (i >= 2) ? 2'h3 : i[1:0], 1'b0});
            end
            $display("soft mode test done");
        end
    endtask
    task t_rev;
        begin
            nvm_rev <= 8'hC3;
            u_host.read(8'h0B, d);
            chk(d, 8'h5A);
            commit <= 1'b1;
            @(posedge sys_clk_in);
            commit <= 1'b0;
            u_host.read(8'h0B, d);
            chk(d, 8'hC3);
            nvm_rev <= 8'h3C;
            en <= 1'b0;
            commit <= 1'b1;
            @(posedge sys_clk_in);
            en <= 1'b1;
            commit <= 1'b0;
            u_host.read(8'h0B, d);
            chk(d, 8'hC3);
            u_host.read(8'h0C, d);
            chk(d, 8'h00);
            $display("revision test done");
        end
    endtask
    task report_and_stop;
        begin
            $display("checked %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge sys_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    initial begin
        t_hard;
        t_soft;
        t_rev;
        report_and_stop;
    end
endmodule // tb_top
